// ---- rtl/out4_pkg.sv ----
package out4_pkg;
  // Register map
  localparam logic [7:0] ADDR_CTL = 8'h25;
  localparam logic [7:0] ADDR_DIV = 8'h26;
  localparam logic [7:0] ADDR_STAT = 8'h27;
  localparam logic [7:0] CTL_RESET = 8'h18;
  localparam logic [7:0] DIV_RESET = 8'h02;
  // Control field positions, all two bits wide
  localparam int CTL_SRC_LSB = 6;
  localparam int CTL_SEL_LSB = 4;
  localparam int CTL_M1_LSB = 2;
  localparam int CTL_M2_LSB = 0;
  localparam int FLD_W = 2;
  // Status bit positions
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_CLK_BIT = 1;
  // Source select codes
  localparam logic [1:0] SRC_SYNTH_ONE = 2'h0;
  localparam logic [1:0] SRC_SYNTH_TWO = 2'h1;
  localparam logic [1:0] SRC_REF_PRI = 2'h2;
  localparam logic [1:0] SRC_REF_SEC = 2'h3;
  // Driver type codes
  localparam logic [1:0] DRV_OFF = 2'h0;
  localparam logic [1:0] DRV_AC = 2'h1;
  localparam logic [1:0] DRV_HCSL = 2'h2;
  localparam logic [1:0] DRV_CMOS = 2'h3;
  // Single-ended pin modes
  localparam logic [1:0] PIN_TRISTATE = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_INVERT = 2'h2;
  localparam logic [1:0] PIN_TRUE = 2'h3;
  // Tail current in mA
  localparam logic [4:0] TAIL_4MA = 5'h04;
  localparam logic [4:0] TAIL_6MA = 5'h06;
  localparam logic [4:0] TAIL_8MA = 5'h08;
  localparam logic [4:0] TAIL_16MA = 5'h10;
  localparam logic [4:0] TAIL_NONE = 5'h00;
  typedef enum logic [1:0] {
    ST_WAIT_NV = 2'b01,
    ST_RUN = 2'b10
  } load_state_t;
endpackage

// ---- rtl/out4_cfg_if.sv ----
`timescale 1ns/10ps
interface out4_cfg_if;
  logic [1:0] src_sel;
  logic [7:0] div_code;
  logic div_clk;
  modport ctl(output src_sel, output div_code, input div_clk);
  modport div(input src_sel, input div_code, output div_clk);
endinterface

// ---- rtl/out4_divider.sv ----
`timescale 1ns/10ps
module out4_divider (
  input wire logic i_ref_clk,   // System clock
  input wire logic i_srst,      // Sync reset, active high
  input wire logic i_synth_one, // Synthesizer one clock level
  input wire logic i_synth_two, // Synthesizer two clock level
  input wire logic i_ref_pri,   // Primary reference level
  input wire logic i_ref_sec,   // Secondary reference level
  out4_cfg_if.div cfg           // Config in, divided clock out
);
  // Sources are sampled, so each must run below half the system clock
  logic src_r, src_nxt, prev_r, prev_nxt, clk_r, clk_nxt;
  logic [7:0] cnt_r, cnt_nxt, half;
  logic rise, is_synth;

  always_comb begin
    case (cfg.src_sel)
      out4_pkg::SRC_SYNTH_ONE: src_nxt = i_synth_one;
      out4_pkg::SRC_SYNTH_TWO: src_nxt = i_synth_two;
      out4_pkg::SRC_REF_PRI: src_nxt = i_ref_pri;
      out4_pkg::SRC_REF_SEC: src_nxt = i_ref_sec;
      default: src_nxt = 1'b0;
    endcase
    prev_nxt = src_r;
    rise = src_r & ~prev_r;
    is_synth = (cfg.src_sel == out4_pkg::SRC_SYNTH_ONE) ||
               (cfg.src_sel == out4_pkg::SRC_SYNTH_TWO);
    // High for ceil(N/2) source periods, N = code + 1
    half = 8'((9'(cfg.div_code) + 9'h002) >> 1);
    cnt_nxt = cnt_r;
    if (rise) begin
      cnt_nxt = (cnt_r >= cfg.div_code) ? 8'h00 : cnt_r + 8'h01;
    end
    if (is_synth && (cfg.div_code != 8'h00)) begin
      clk_nxt = (cnt_r < half);
    end else begin
      clk_nxt = src_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      src_r <= 1'b0;
      prev_r <= 1'b0;
      clk_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      src_r <= src_nxt;
      prev_r <= prev_nxt;
      clk_r <= clk_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign cfg.div_clk = clk_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_src_route_two: assert property (
    cfg.src_sel == out4_pkg::SRC_SYNTH_TWO |=> src_r == $past(i_synth_two))
    else $error("synthesizer two not routed");
  chk_div_wrap: assert property (
    rise && cnt_r >= cfg.div_code |=> cnt_r == 8'h00)
    else $error("divider count did not wrap");
  chk_ref_bypass: assert property (
    !is_synth |=> clk_r == $past(src_r))
    else $error("reference source was divided");
endmodule

// ---- rtl/clock_output_channel_four_control.sv ----
`timescale 1ns/10ps
//
// Operation
// - Source code 0..3 picks synth1, synth2, refs
// - Type code: off, AC diff, HCSL, LVCMOS
// - First mode sets differential tail current
// - First mode controls LVCMOS positive pin
// - Second mode: HCSL load or negative pin
// - Eight-bit divider divides by code plus one
// - Divider only for synthesizer sources
module clock_output_channel_four_control (
  input wire logic i_ref_clk,       // 20 MHz system clock
  input wire logic i_srst,          // Sync reset, active high
  input wire logic [7:0] i_addr,    // Register address
  input wire logic [7:0] i_wdata,   // Register write data
  input wire logic i_wr,            // Write strobe
  input wire logic i_rd,            // Read strobe
  output logic [7:0] o_rdata,       // Read data, cycle after strobe
  input wire logic i_nv_load,       // Stored image valid strobe
  input wire logic [7:0] i_nv_ctrl, // Stored control byte
  input wire logic [7:0] i_nv_div,  // Stored divider byte
  input wire logic i_synth_one,     // Synthesizer one clock
  input wire logic i_synth_two,     // Synthesizer two clock
  input wire logic i_ref_pri,       // Primary reference clock
  input wire logic i_ref_sec,       // Secondary reference clock
  output logic o_out_p,             // Positive pin level
  output logic o_out_p_oe,          // Positive pin drive enable
  output logic o_out_n,             // Negative pin level
  output logic o_out_n_oe,          // Negative pin drive enable
  output logic [4:0] o_tail_ma,     // Tail current in mA, 0 if none
  output logic [1:0] o_hcsl_load    // HCSL load code, 0 otherwise
);
  out4_cfg_if cfg ();
  out4_pkg::load_state_t state_r, state_nxt;
  logic [7:0] ctl_r, ctl_nxt, div_r, div_nxt, rdata_nxt;
  logic p_nxt, p_oe_nxt, n_nxt, n_oe_nxt;
  logic [4:0] tail_nxt;
  logic [1:0] load_nxt, src, sel, mode1, mode2;
  logic clk;

  out4_divider u_div (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_synth_one(i_synth_one),
    .i_synth_two(i_synth_two),
    .i_ref_pri(i_ref_pri),
    .i_ref_sec(i_ref_sec),
    .cfg(cfg.div)
  );

  assign src = ctl_r[out4_pkg::CTL_SRC_LSB +: out4_pkg::FLD_W];
  assign sel = ctl_r[out4_pkg::CTL_SEL_LSB +: out4_pkg::FLD_W];
  assign mode1 = ctl_r[out4_pkg::CTL_M1_LSB +: out4_pkg::FLD_W];
  assign mode2 = ctl_r[out4_pkg::CTL_M2_LSB +: out4_pkg::FLD_W];
  assign cfg.src_sel = src;
  assign cfg.div_code = div_r;
  assign clk = cfg.div_clk;

  // Returns {enable, level} of one single-ended pin
  function automatic logic [1:0] cmos_pin(input logic [1:0] mode,
                                          input logic c);
    case (mode)
      out4_pkg::PIN_TRISTATE: cmos_pin = 2'b00;
      out4_pkg::PIN_LOW: cmos_pin = 2'b10;
      out4_pkg::PIN_INVERT: cmos_pin = {1'b1, ~c};
      out4_pkg::PIN_TRUE: cmos_pin = {1'b1, c};
      default: cmos_pin = 2'b00;
    endcase
  endfunction

  function automatic logic [4:0] tail_of(input logic [1:0] mode,
                                         input logic hcsl);
    case (mode)
      2'h0: tail_of = out4_pkg::TAIL_4MA;
      2'h1: tail_of = out4_pkg::TAIL_6MA;
      2'h2: tail_of = out4_pkg::TAIL_8MA;
      2'h3: tail_of = hcsl ? out4_pkg::TAIL_16MA : out4_pkg::TAIL_8MA;
      default: tail_of = out4_pkg::TAIL_NONE;
    endcase
  endfunction

  // Registers and stored-image load
  always_comb begin
    state_nxt = state_r;
    ctl_nxt = ctl_r;
    div_nxt = div_r;
    if (i_wr && i_addr == out4_pkg::ADDR_CTL) begin
      ctl_nxt = i_wdata;
    end
    if (i_wr && i_addr == out4_pkg::ADDR_DIV) begin
      div_nxt = i_wdata;
    end
    case (state_r)
      out4_pkg::ST_WAIT_NV: begin
        // Image wins over a same-cycle bus write
        if (i_nv_load) begin
          ctl_nxt = i_nv_ctrl;
          div_nxt = i_nv_div;
          state_nxt = out4_pkg::ST_RUN;
        end
      end
      out4_pkg::ST_RUN: state_nxt = out4_pkg::ST_RUN;
      default: state_nxt = out4_pkg::ST_WAIT_NV;
    endcase
    rdata_nxt = 8'h00;
    if (i_rd) begin
      case (i_addr)
        out4_pkg::ADDR_CTL: rdata_nxt = ctl_r;
        out4_pkg::ADDR_DIV: rdata_nxt = div_r;
        out4_pkg::ADDR_STAT: begin
          rdata_nxt[out4_pkg::STAT_RUN_BIT] = (state_r == out4_pkg::ST_RUN);
          rdata_nxt[out4_pkg::STAT_CLK_BIT] = clk;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= out4_pkg::ST_WAIT_NV;
      ctl_r <= out4_pkg::CTL_RESET;
      div_r <= out4_pkg::DIV_RESET;
      o_rdata <= 8'h00;
    end else begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      div_r <= div_nxt;
      o_rdata <= rdata_nxt;
    end
  end

  // Output driver
  always_comb begin
    p_nxt = 1'b0;
    p_oe_nxt = 1'b0;
    n_nxt = 1'b0;
    n_oe_nxt = 1'b0;
    tail_nxt = out4_pkg::TAIL_NONE;
    load_nxt = 2'h0;
    if (state_r == out4_pkg::ST_RUN) begin
      case (sel)
        out4_pkg::DRV_OFF: p_nxt = 1'b0;
        out4_pkg::DRV_AC, out4_pkg::DRV_HCSL: begin
          p_nxt = clk;
          n_nxt = ~clk;
          p_oe_nxt = 1'b1;
          n_oe_nxt = 1'b1;
          tail_nxt = tail_of(mode1, sel == out4_pkg::DRV_HCSL);
          if (sel == out4_pkg::DRV_HCSL) begin
            load_nxt = mode2;
          end
        end
        out4_pkg::DRV_CMOS: begin
          {p_oe_nxt, p_nxt} = cmos_pin(mode1, clk);
          {n_oe_nxt, n_nxt} = cmos_pin(mode2, clk);
        end
        default: p_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_out_p <= 1'b0;
      o_out_p_oe <= 1'b0;
      o_out_n <= 1'b0;
      o_out_n_oe <= 1'b0;
      o_tail_ma <= out4_pkg::TAIL_NONE;
      o_hcsl_load <= 2'h0;
    end else begin
      o_out_p <= p_nxt;
      o_out_p_oe <= p_oe_nxt;
      o_out_n <= n_nxt;
      o_out_n_oe <= n_oe_nxt;
      o_tail_ma <= tail_nxt;
      o_hcsl_load <= load_nxt;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_type_disabled: assert property (
    sel == out4_pkg::DRV_OFF |=> !o_out_p_oe && !o_out_n_oe &&
      o_tail_ma == out4_pkg::TAIL_NONE)
    else $error("disabled channel still drives");
  chk_tail_hcsl: assert property (
    state_r == out4_pkg::ST_RUN && sel == out4_pkg::DRV_HCSL &&
      mode1 == 2'h3 |=> o_tail_ma == out4_pkg::TAIL_16MA &&
      o_out_n == !o_out_p)
    else $error("HCSL tail current wrong");
  chk_cmos_pos_pin: assert property (
    state_r == out4_pkg::ST_RUN && sel == out4_pkg::DRV_CMOS &&
      mode1 == out4_pkg::PIN_INVERT |=> o_out_p_oe &&
      o_out_p == !$past(clk))
    else $error("positive pin polarity wrong");
  chk_cmos_neg_pin: assert property (
    state_r == out4_pkg::ST_RUN && sel == out4_pkg::DRV_CMOS &&
      mode2 == out4_pkg::PIN_LOW |=> o_out_n_oe && !o_out_n)
    else $error("negative pin not held low");
  chk_load_before_run: assert property (
    state_r == out4_pkg::ST_WAIT_NV && i_nv_load |=>
      ctl_r == $past(i_nv_ctrl) && div_r == $past(i_nv_div) ##1
      (o_out_p_oe == ($past(sel) != out4_pkg::DRV_OFF &&
        ($past(sel) != out4_pkg::DRV_CMOS ||
        $past(mode1) != out4_pkg::PIN_TRISTATE))))
    else $error("stored image not applied");
  chk_tail_ac: assert property (
    state_r == out4_pkg::ST_RUN && sel == out4_pkg::DRV_AC &&
      mode1 == 2'h3 |=> o_tail_ma == out4_pkg::TAIL_8MA)
    else $error("AC tail current wrong");
  chk_hcsl_load: assert property (
    state_r == out4_pkg::ST_RUN && sel == out4_pkg::DRV_HCSL |=>
      o_hcsl_load == $past(mode2))
    else $error("HCSL load code wrong");
  chk_cmos_tristate: assert property (
    state_r == out4_pkg::ST_RUN && sel == out4_pkg::DRV_CMOS &&
      mode1 == out4_pkg::PIN_TRISTATE |=> !o_out_p_oe)
    else $error("positive pin not tristated");
  chk_wait_quiet: assert property (
    state_r == out4_pkg::ST_WAIT_NV |=> !o_out_p_oe && !o_out_n_oe &&
      o_tail_ma == out4_pkg::TAIL_NONE && o_hcsl_load == 2'h0)
    else $error("output enabled before image load");
  chk_image_once: assert property (
    state_r == out4_pkg::ST_RUN && i_nv_load && !i_wr |=>
      ctl_r == $past(ctl_r) && div_r == $past(div_r))
    else $error("stored image reloaded");
endmodule

// ---- sim/out4_receiver.sv ----
`timescale 1ns/10ps
module out4_receiver (
  input wire logic i_p,     // Positive pin level
  input wire logic i_p_oe,  // Positive pin enable
  input wire logic i_n,     // Negative pin level
  input wire logic i_n_oe,  // Negative pin enable
  output logic o_p_wire,    // Resolved positive line
  output logic o_n_wire,    // Resolved negative line
  output int o_rise         // Rising edges on positive line
);
  logic last_p = 1'b0;
  logic last_n = 1'b0;
  initial o_rise = 0;
  // No pull on the lines: undriven shows the inverse of the last level
  always @* if (i_p_oe) last_p = i_p;
  always @* if (i_n_oe) last_n = i_n;
  assign o_p_wire = i_p_oe ? i_p : ~last_p;
  assign o_n_wire = i_n_oe ? i_n : ~last_n;
  always @(posedge o_p_wire) o_rise++;
endmodule

// ---- sim/clock_output_channel_four_control_tb.sv ----
`timescale 1ns/10ps
module clock_output_channel_four_control_tb;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_nv_load = 1'b0;
  logic [7:0] i_nv_ctrl = 8'h00;
  logic [7:0] i_nv_div = 8'h00;
  logic [3:0] src = 4'h0;
  logic [7:0] o_rdata;
  logic o_out_p, o_out_p_oe, o_out_n, o_out_n_oe, p_w, n_w;
  logic [4:0] o_tail_ma;
  logic [1:0] o_hcsl_load;
  logic [7:0] rv;
  int rise, tick = 0, fail_count = 0, n_compared = 0;
  int half_c [4] = '{6, 5, 9, 11};
  int src_rise [4] = '{0, 0, 0, 0};
  always #25 i_ref_clk = ~i_ref_clk;
  // Sources well below half the sampling clock
  always @(posedge i_ref_clk) begin
    tick <= tick + 1;
    for (int k = 0; k < 4; k++) begin
      if (tick % half_c[k] == 0) begin
        src[k] <= ~src[k];
        if (!src[k]) src_rise[k]++;
      end
    end
  end
  clock_output_channel_four_control dut_u (.i_ref_clk(i_ref_clk),
    .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_nv_load(i_nv_load),
    .i_nv_ctrl(i_nv_ctrl), .i_nv_div(i_nv_div), .i_synth_one(src[0]),
    .i_synth_two(src[1]), .i_ref_pri(src[2]), .i_ref_sec(src[3]),
    .o_out_p(o_out_p), .o_out_p_oe(o_out_p_oe), .o_out_n(o_out_n),
    .o_out_n_oe(o_out_n_oe), .o_tail_ma(o_tail_ma),
    .o_hcsl_load(o_hcsl_load));
  out4_receiver rx_u (.i_p(o_out_p), .i_p_oe(o_out_p_oe), .i_n(o_out_n),
    .i_n_oe(o_out_n_oe), .o_p_wire(p_w), .o_n_wire(n_w), .o_rise(rise));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] m = 8'hFF);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata & m, exp);
  endtask
  function automatic logic [4:0] exp_tail(input logic [7:0] c);
    if (c[5:4] == 2'h0 || c[5:4] == 2'h3) return 5'h00;
    case (c[3:2])
      2'h0: return 5'h04;
      2'h1: return 5'h06;
      2'h2: return 5'h08;
      default: return (c[5:4] == 2'h2) ? 5'h10 : 5'h08;
    endcase
  endfunction
  function automatic logic exp_oe(input logic [1:0] t, input logic [1:0] m);
    return (t == 2'h1 || t == 2'h2 || (t == 2'h3 && m != 2'h0));
  endfunction
  task automatic cfg_chk(input logic [7:0] c);
    wr(8'h25, c);
    repeat (4) @(posedge i_ref_clk);
    #1 check(o_tail_ma, exp_tail(c));
    check(o_out_p_oe, exp_oe(c[5:4], c[3:2]));
    check(o_out_n_oe, exp_oe(c[5:4], c[1:0]));
    check(o_hcsl_load, (c[5:4] == 2'h2) ? c[1:0] : 2'h0);
    if (c[5:4] == 2'h3 && c[3:2] == 2'h1) check(p_w, 1'b0);
    if (c[5:4] == 2'h3 && c[1:0] == 2'h1) check(n_w, 1'b0);
  endtask
  task automatic div_chk(input logic [1:0] s, input logic [7:0] d);
    int r0, s0, got, exp;
    wr(8'h25, {s, 6'h10});
    wr(8'h26, d);
    repeat (40) @(posedge i_ref_clk);
    r0 = rise;
    s0 = src_rise[s];
    repeat (600) @(posedge i_ref_clk);
    got = rise - r0;
    exp = (src_rise[s] - s0) / ((s < 2'h2) ? d + 1 : 1);
    n_compared++;
    if (got > exp + 1 || got < exp - 1) begin
      fail_count++;
      $display("mismatch at %0t: edges %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(50 * 60000);
    fail_count++;
    close_out();
  end
  initial begin
    rv = $urandom(5267);
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(8'h25, 8'h18);
    rd(8'h26, 8'h02);
    rd(8'h40, 8'h00);
    check(o_out_p_oe | o_out_n_oe, 1'b0);
    @(posedge i_ref_clk);
    i_nv_load <= 1'b1;
    i_nv_ctrl <= 8'h10;
    i_nv_div <= 8'h01;
    @(posedge i_ref_clk);
    i_nv_load <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 check(o_out_p_oe & o_out_n_oe, 1'b1);
    rd(8'h25, 8'h10);
    rd(8'h26, 8'h01);
    // A second image pulse after the first load must be ignored
    @(posedge i_ref_clk);
    i_nv_load <= 1'b1;
    i_nv_ctrl <= 8'hC0;
    @(posedge i_ref_clk);
    i_nv_load <= 1'b0;
    rd(8'h25, 8'h10);
    rd(8'h27, 8'h01, 8'h01);
    $display("test reset and image done");
    for (int c = 0; c < 64; c++) cfg_chk(c[7:0]);
    for (int k = 0; k < 20; k++) begin
      cfg_chk({2'h3, 2'h3, 2'h2 + k[1:1], 2'h3});
      repeat (k) @(posedge i_ref_clk);
      #1 check(p_w, k[1] ? n_w : !n_w);
    end
    $display("test driver modes done");
    div_chk(2'h0, 8'h00);
    div_chk(2'h0, 8'h01);
    div_chk(2'h1, 8'h02);
    div_chk(2'h2, 8'h04);
    div_chk(2'h3, 8'h07);
    for (int k = 0; k < 3; k++) begin
      div_chk(2'($urandom % 4), 8'($urandom % 6));
    end
    $display("test divider done");
    for (int k = 0; k < 12; k++) begin
      rv = 8'($urandom);
      wr(8'h25 + k[0], rv);
      wr(8'h41, ~rv);
      rd(8'h25 + k[0], rv);
      rd(8'h41, 8'h00);
    end
    wr(8'h26, 8'hFF);
    rd(8'h26, 8'hFF);
    $display("test registers done");
    // Mid-run reset returns to waiting for the image, outputs quiet
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    #1 check(o_out_p_oe | o_out_n_oe | o_tail_ma, 8'h00);
    rd(8'h25, 8'h18);
    rd(8'h26, 8'h02);
    rd(8'h27, 8'h00, 8'h01);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
